// File: core/reset_source_status.sv
// reset source status register with low-voltage detect interrupt, apb slave
// Notes on behaviour
// - reading the status register clears the four cause flags
// - status is read-only; writes go to a separate write-only register
// - power-on/brownout flag set by that reset, cleared by watchdog, stop recovery, read
// - stop flag set on every stop recovery except the debug pin one; with watchdog flag means watchdog recovery
// - stop flag cleared by power-on, watchdog outside stop, or read
// - watchdog flag set on time-out; cleared by power-on, pin-change recovery, read
// - external flag set by reset pin; cleared by power-on, pin recovery, read
// - bits three to one always read zero
// - low-voltage bit shows the live detector level, not latched, resets zero
// - debugger-register reset leaves only the power-on flag set
// - debug pin low out of stop leaves only the power-on flag set
// - general pin stop recovery leaves only the stop flag set
// - enabled low-voltage detector raises an interrupt capturing transients
// - power control bit four enables the low-voltage detector
`timescale 1ns/100ps
`default_nettype none
module reset_source_status
  import rss_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [RSS_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // reset and recovery events, asynchronous levels from the power domain
  input  wire logic                  supply_brownout_reset,
  input  wire logic                  ext_reset_evt,
  input  wire logic                  wdt_timeout_evt,
  input  wire logic                  debugger_reset_evt,
  input  wire logic                  debug_pin_stop_evt,
  input  wire logic                  pin_change_recovery_evt,
  input  wire logic                  in_stop_mode,
  input  wire logic                  low_voltage_raw,
  // results
  output logic                       low_voltage_en,
  output logic [7:0]                 write_only_reg,
  output logic                       irq
);
  typedef enum logic [1:0] {
    RSS_IDLE   = 2'b01,
    RSS_ACCESS = 2'b10
  } rss_state_e;

  localparam int N_IN = 8;

  rss_state_e       state_r;
  logic [N_IN-1:0]  raw_lvl;
  logic [N_IN-1:0]  syn_lvl;
  logic [5:0]       ev_pulse;
  logic             ev_bor;
  logic             ev_ext;
  logic             ev_wdt;
  logic             ev_dbg;
  logic             ev_dpin;
  logic             ev_pin;
  logic             stop_lvl;
  logic             lvd_lvl;
  logic [3:0]       cause_r;
  logic [3:0]       cause_nxt;
  logic [7:0]       pwrctl_r;
  logic [RSS_EV_W-1:0] ists_r;
  logic [RSS_EV_W-1:0] imsk_r;
  logic [RSS_EV_W-1:0] ev_set;
  logic             lvd_prev_r;
  logic             acc;
  logic             wr_acc;
  logic             rd_acc;
  logic             hit;
  logic [7:0]       status_view;
  logic [31:0]      rd_mux;

  // ==========================================================================
  // input conditioning
  assign raw_lvl = {low_voltage_raw, in_stop_mode, pin_change_recovery_evt, debug_pin_stop_evt,
                    debugger_reset_evt, wdt_timeout_evt, ext_reset_evt, supply_brownout_reset};

  rss_sync #(.W(N_IN)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (raw_lvl),
    .dout    (syn_lvl)
  );

  // only the six event inputs need edges; stop and low-voltage are levels
  rss_edge #(.W(6)) u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .lvl     (syn_lvl[5:0]),
    .pulse   (ev_pulse)
  );

  assign ev_bor   = ev_pulse[0];
  assign ev_ext   = ev_pulse[1];
  assign ev_wdt   = ev_pulse[2];
  assign ev_dbg   = ev_pulse[3];
  assign ev_dpin  = ev_pulse[4];
  assign ev_pin   = ev_pulse[5];
  assign stop_lvl = syn_lvl[6];
  assign lvd_lvl  = syn_lvl[7] & pwrctl_r[RSS_LVDEN_BIT];

  // ==========================================================================
  // apb handshake: one wait-free access phase, pready registered
  assign acc    = psel & penable & pready;
  assign wr_acc = acc & pwrite;
  assign rd_acc = acc & ~pwrite;
  assign hit    = (paddr == RSS_STATUS_OFS) || (paddr == RSS_PWRCTL_OFS) ||
                  (paddr == RSS_IRQ_STS_OFS) || (paddr == RSS_IRQ_MSK_OFS);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= RSS_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      case (state_r)
        RSS_IDLE:
        begin
          if (psel && !penable)
          begin
            state_r <= RSS_ACCESS;
            pready  <= 1'b1;
            pslverr <= ~hit;  // unmapped address answers with an error
          end
        end
        RSS_ACCESS:
        begin
          state_r <= RSS_IDLE;
          pready  <= 1'b0;
          pslverr <= 1'b0;
        end
        default:
        begin
          state_r <= RSS_IDLE;
          pready  <= 1'b0;
          pslverr <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // cause flags {por, stop, wdt, ext}; last event wins, read clears
  always_comb
  begin
    cause_nxt = cause_r;
    // clear only what the captured read data showed: an event landing
    // between setup and access would otherwise be lost unseen
    if (rd_acc && paddr == RSS_STATUS_OFS)
      cause_nxt = cause_r & ~prdata[7:4];
    // events after the read clear so a same-cycle event is kept
    if (ev_bor || ev_dbg || ev_dpin)
      cause_nxt = 4'h8;
    else if (ev_wdt && stop_lvl)
      cause_nxt = 4'h6;
    else if (ev_wdt)
      cause_nxt = 4'h2;
    else if (ev_pin)
      cause_nxt = 4'h4;
    else if (ev_ext)
      cause_nxt = 4'h1;
  end

  // writes never touch cause_r
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cause_r <= RSS_CAUSE_RST;
    else
      cause_r <= cause_nxt;
  end

  // ==========================================================================
  // write-only partner and power control
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      write_only_reg <= RSS_WO_RST;
      pwrctl_r       <= RSS_PWRCTL_RST;
      imsk_r         <= RSS_MSK_RST;
    end
    else if (wr_acc)
    begin
      if (paddr == RSS_STATUS_OFS)
        write_only_reg <= pwdata[7:0];
      if (paddr == RSS_PWRCTL_OFS)
        pwrctl_r <= pwdata[7:0];
      if (paddr == RSS_IRQ_MSK_OFS)
        imsk_r <= pwdata[RSS_EV_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_voltage_en <= 1'b0;
    else
      low_voltage_en <= pwrctl_r[RSS_LVDEN_BIT];
  end

  // ==========================================================================
  // sticky interrupt status; set beats write-one-to-clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lvd_prev_r <= 1'b0;
    else
      lvd_prev_r <= lvd_lvl;
  end

  always_comb
  begin
    ev_set               = '0;
    ev_set[RSS_EV_LVD]   = lvd_lvl & ~lvd_prev_r;
    ev_set[RSS_EV_CAUSE] = ev_bor | ev_ext | ev_dbg | ev_dpin | ev_pin;
    ev_set[RSS_EV_WDT]   = ev_wdt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ists_r <= '0;
    else if (wr_acc && paddr == RSS_IRQ_STS_OFS)
      ists_r <= (ists_r & ~pwdata[RSS_EV_W-1:0]) | ev_set;
    else
      ists_r <= ists_r | ev_set;
  end

  // registered level interrupt
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |((ists_r | ev_set) & imsk_r);
  end

  // ==========================================================================
  // read data; live low-voltage bit, reserved bits zero
  always_comb
  begin
    status_view               = {cause_r, 3'h0, 1'b0};
    status_view[RSS_LVD_BIT]  = lvd_lvl;
    rd_mux                    = 32'h0;
    case (paddr)
      RSS_STATUS_OFS:  rd_mux = {24'h0, status_view};
      RSS_PWRCTL_OFS:  rd_mux = {24'h0, pwrctl_r};
      RSS_IRQ_STS_OFS: rd_mux = {29'h0, ists_r};
      RSS_IRQ_MSK_OFS: rd_mux = {29'h0, imsk_r};
      default:         rd_mux = 32'h0;
    endcase
  end

  // captured in setup so data stands during the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
    else if (!psel)
      prdata <= 32'h0;
  end

  // ==========================================================================
  // checks
  wr_keeps_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == RSS_STATUS_OFS && ev_pulse[5:0] == 6'h0) |=> cause_r == $past(cause_r))
    else $error("write changed cause flags");
  rd_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && paddr == RSS_STATUS_OFS && ev_pulse[5:0] == 6'h0 && $stable(cause_r))
    |=> cause_r == 4'h0)
    else $error("read did not clear cause flags");
  por_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ev_bor || ev_dbg || ev_dpin) |=> cause_r == 4'h8)
    else $error("power-on flag pattern wrong");
  stop_wdt_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ev_wdt && stop_lvl && !ev_bor && !ev_dbg && !ev_dpin) |=> cause_r == 4'h6)
    else $error("stop watchdog pattern wrong");
  wdt_run_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ev_wdt && !stop_lvl && !ev_bor && !ev_dbg && !ev_dpin) |=> cause_r == 4'h2)
    else $error("watchdog pattern wrong");
  pin_rec_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ev_pin && !ev_wdt && !ev_bor && !ev_dbg && !ev_dpin) |=> cause_r == 4'h4)
    else $error("pin recovery pattern wrong");
  rsvd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && paddr == RSS_STATUS_OFS) |-> prdata[3:1] == 3'h0)
    else $error("reserved bits not zero");
  lvd_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(lvd_lvl) && imsk_r[RSS_EV_LVD]) |=> ##[0:1] irq)
    else $error("low voltage interrupt missing");
  lvd_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && paddr == RSS_STATUS_OFS && !$past(pwrctl_r[RSS_LVDEN_BIT]))
    |-> !prdata[RSS_LVD_BIT])
    else $error("disabled detector reported low voltage");
endmodule : reset_source_status
`default_nettype wire

// File: core/rss_pkg.sv
// package: register map, field positions and reset values of the reset source status block
package rss_pkg;
  // ==========================================================================
  // register map (byte addresses on apb)
  localparam logic [11:0] RSS_STATUS_OFS  = 12'hff0;  // status read, write-only partner on write
  localparam logic [11:0] RSS_PWRCTL_OFS  = 12'hff4;  // power control
  localparam logic [11:0] RSS_IRQ_STS_OFS = 12'hff8;  // sticky event status, write one to clear
  localparam logic [11:0] RSS_IRQ_MSK_OFS = 12'hffc;  // interrupt mask
  localparam int          RSS_ADDR_W      = 12;

  // ==========================================================================
  // status field positions
  localparam int RSS_POR_BIT  = 7;
  localparam int RSS_STOP_BIT = 6;
  localparam int RSS_WDT_BIT  = 5;
  localparam int RSS_EXT_BIT  = 4;
  localparam int RSS_LVD_BIT  = 0;
  localparam int RSS_LVDEN_BIT = 4;  // power control enable bit

  // ==========================================================================
  // interrupt status layout
  localparam int RSS_EV_W     = 3;
  localparam int RSS_EV_LVD   = 0;  // low voltage seen
  localparam int RSS_EV_CAUSE = 1;  // a reset cause other than watchdog was recorded
  localparam int RSS_EV_WDT   = 2;  // watchdog time-out

  // ==========================================================================
  // reset values
  localparam logic [3:0] RSS_CAUSE_RST  = 4'h8;  // power-on sets only the power-on flag
  localparam logic [7:0] RSS_PWRCTL_RST = 8'h00;
  localparam logic [7:0] RSS_WO_RST     = 8'h00;
  localparam logic [2:0] RSS_MSK_RST    = 3'h0;
endpackage : rss_pkg

// File: core/rss_sync.sv
// two-flop synchroniser bank for asynchronous inputs
`timescale 1ns/100ps
`default_nettype none
module rss_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);
  logic [W-1:0] meta_r;

  // a zero-width bank cannot be built
  if (W < 1)
  begin : g_bad_w
    $error("rss_sync width must be at least one");
  end

  // ==========================================================================
  // first stage is read only by the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= '0;
      dout   <= '0;
    end
    else
    begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule : rss_sync
`default_nettype wire

// File: core/rss_edge.sv
// rising edge pulser for synchronised event levels, one per bit
`timescale 1ns/100ps
`default_nettype none
module rss_edge #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] lvl,
  output logic      [W-1:0] pulse
);
  logic [W-1:0] prev_r;

  // a zero-width bank cannot be built
  if (W < 1)
  begin : g_bad_w
    $error("rss_edge width must be at least one");
  end

  // ==========================================================================
  // delayed copy; cleared to the idle low level so reset leaves no false edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev_r <= '0;
    else
      prev_r <= lvl;
  end

  assign pulse = lvl & ~prev_r;
endmodule : rss_edge
`default_nettype wire

// File: testbench/tb.sv
// self-checking testbench for the reset source status block
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb;
  import rss_pkg::*;
  // ==========================================================================
  // signals
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  ev;
  logic        stop_lvl;
  logic        lv_raw;
  logic        lv_en;
  logic [7:0]  wo_reg;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  logic [31:0] pw;
  int          err_total;
  int          cmp_count;
  int          k1;
  int          k2;
  bit          s1;
  bit          s2;

  // ==========================================================================
  // device under test, every event input driven from the bench
  reset_source_status dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_brownout_reset(ev[0]), .ext_reset_evt(ev[1]), .wdt_timeout_evt(ev[2]),
    .debugger_reset_evt(ev[3]), .debug_pin_stop_evt(ev[4]),
    .pin_change_recovery_evt(ev[5]), .in_stop_mode(stop_lvl), .low_voltage_raw(lv_raw),
    .low_voltage_en(lv_en), .write_only_reg(wo_reg), .irq(irq)
  );

  // ==========================================================================
  // clock, 40 ns period
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  // ==========================================================================
  // helpers
  // expected cause nibble per event: 0 brownout 1 ext 2 wdt 3 debugger 4 debug pin 5 pin
  function automatic logic [3:0] exp_cause(input int k, input bit s);
    case (k)
      1: return 4'h1;
      2: return s ? 4'h6 : 4'h2;
      5: return 4'h4;
      default: return 4'h8;
    endcase
  endfunction : exp_cause

  // apb transfer; waits for pready under a bound instead of assuming latency
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    `CHK(n < 50, 1'b1)
  endtask : apb

  task automatic rd_exp(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
    `CHK(er, 1'b0)
  endtask : rd_exp

  // event pulse; stop level raised first so the synchroniser sees it in time
  task automatic fire(input int k, input bit s);
    @(posedge pclk);
    stop_lvl <= s;
    repeat (3) @(posedge pclk);
    ev[k] <= 1'b1;
    repeat (3) @(posedge pclk);
    ev[k] <= 1'b0;
    repeat (5) @(posedge pclk);
    stop_lvl <= 1'b0;
  endtask : fire

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  // ==========================================================================
  // watchdog, far beyond the several hundred cycles the tests need
  initial
  begin
    #(40 * 20000);
    err_total++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    stop_test();
  end

  // ==========================================================================
  // main sequence
  initial
  begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; ev = 6'h00; stop_lvl = 1'b0; lv_raw = 1'b0;
    err_total = 0;
    cmp_count = 0;
    void'($urandom(32'h2f86));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd_exp(RSS_STATUS_OFS, 32'h80);
    rd_exp(RSS_STATUS_OFS, 32'h00);
    rd_exp(RSS_PWRCTL_OFS, 32'h0);
    rd_exp(RSS_IRQ_STS_OFS, 32'h0);
    rd_exp(RSS_IRQ_MSK_OFS, 32'h0);
    `CHK(wo_reg, RSS_WO_RST)
    $display("test reset done");
    // every event alone, watchdog both in and out of stop
    for (int i = 0; i < 7; i++)
    begin
      k1 = (i == 6) ? 2 : i;
      s1 = (i == 6);
      apb(1'b1, RSS_IRQ_STS_OFS, 32'h7);
      fire(k1, s1);
      rd_exp(RSS_STATUS_OFS, {24'h0, exp_cause(k1, s1), 4'h0});
      rd_exp(RSS_IRQ_STS_OFS, (k1 == 2) ? 32'h4 : 32'h2);
    end
    $display("test single events done");
    // random pairs without a read between: the later event decides
    for (int i = 0; i < 12; i++)
    begin
      k1 = $urandom % 6;
      s1 = $urandom % 2;
      k2 = $urandom % 6;
      s2 = $urandom % 2;
      fire(k1, s1);
      fire(k2, s2);
      rd_exp(RSS_STATUS_OFS, {24'h0, exp_cause(k2, s2), 4'h0});
      rd_exp(RSS_STATUS_OFS, 32'h0);
    end
    $display("test event pairs done");
    // writes to the status address and to an unmapped one leave the flags alone
    fire(1, 1'b0);
    pw = $urandom;
    apb(1'b1, RSS_STATUS_OFS, pw);
    @(posedge pclk);
    `CHK(wo_reg, pw[7:0])
    apb(1'b1, 12'h100, 32'hff);
    `CHK(er, 1'b1)
    rd_exp(RSS_STATUS_OFS, 32'h10);
    $display("test write path done");
    // cause interrupt: raise, read status first, then clear
    apb(1'b1, RSS_IRQ_STS_OFS, 32'h7);
    apb(1'b1, RSS_IRQ_MSK_OFS, 32'h2);
    fire(5, 1'b0);
    `CHK(irq, 1'b1)
    rd_exp(RSS_STATUS_OFS, 32'h40);
    apb(1'b1, RSS_IRQ_STS_OFS, 32'h2);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    // low-voltage: gated while disabled, live when enabled, interrupt sticky
    apb(1'b1, RSS_IRQ_MSK_OFS, 32'h1);
    lv_raw <= 1'b1;
    repeat (6) @(posedge pclk);
    rd_exp(RSS_STATUS_OFS, 32'h0);
    `CHK(irq, 1'b0)
    lv_raw <= 1'b0;
    apb(1'b1, RSS_PWRCTL_OFS, 32'h10);
    repeat (2) @(posedge pclk);
    `CHK(lv_en, 1'b1)
    lv_raw <= 1'b1;
    repeat (6) @(posedge pclk);
    rd_exp(RSS_STATUS_OFS, 32'h1);
    lv_raw <= 1'b0;
    repeat (6) @(posedge pclk);
    rd_exp(RSS_STATUS_OFS, 32'h0);
    `CHK(irq, 1'b1)
    apb(1'b1, RSS_IRQ_STS_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    $display("test low voltage done");
    // second reset in mid-run restores the power-on pattern
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_exp(RSS_STATUS_OFS, 32'h80);
    `CHK(lv_en, 1'b0)
    $display("test second reset done");
    stop_test();
  end
endmodule : tb
`default_nettype wire
